// ### rtl/bfail_pkg.sv
// package of constants and carriers for the breaker failure delay logic
package bfail_pkg;
   // =====================================================
   // criteria and timing
   // =====================================================
   typedef enum logic [1:0] {
      CRIT_CURRENT = 2'h0,
      CRIT_CUR_AND_OUT = 2'h1,
      CRIT_CUR_OR_OUT = 2'h2,
      CRIT_INPUT = 2'h3
   } criterion_t;

   // state: normal -> start -> failed along gray path, blocked off it
   typedef enum logic [1:0] {
      ST_NORMAL = 2'h0,
      ST_START = 2'h1,
      ST_FAILED = 2'h3,
      ST_BLOCKED = 2'h2
   } bf_state_t;

   localparam real TICK_NS = 100.0;
   localparam real STEP_S = 0.005;
   localparam real DEFAULT_FAIL_S = 0.200;
   localparam real DEFAULT_RETRIP_S = 0.100;
   localparam int DELAY_W = 20;
   localparam logic [DELAY_W-1:0] DEFAULT_FAIL_STEPS = DELAY_W'(int'(DEFAULT_FAIL_S / STEP_S));
   localparam logic [DELAY_W-1:0] DEFAULT_RETRIP_STEPS =
      DELAY_W'(int'(DEFAULT_RETRIP_S / STEP_S));
   localparam int STEP_CYCLES = int'(STEP_S * 1.0E9 / TICK_NS);
   localparam int CUR_W = 16;
   localparam int TS_W = 48;
   localparam int CNT_W = 16;
   localparam int LOG_DEPTH = 12;
   localparam int LOG_AW = 4;
   localparam logic [LOG_AW-1:0] LOG_LAST = LOG_AW'(LOG_DEPTH - 1);
   localparam int NUM_EV = 8;
   localparam int GROUP_W = 3;

   // event indices
   localparam int EV_START = 0;
   localparam int EV_RETRIP = 1;
   localparam int EV_FAIL = 2;
   localparam int EV_BLOCK = 3;
   localparam int EV_OUTMON = 4;
   localparam int EV_SIGNAL = 5;
   localparam int EV_PHASE = 6;
   localparam int EV_RES = 7;

   // register bus map
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] REG_FAIL_DELAY = 8'h04;
   localparam logic [ADDR_W-1:0] REG_RETRIP_DELAY = 8'h08;
   localparam logic [ADDR_W-1:0] REG_PHASE_LVL = 8'h0C;
   localparam logic [ADDR_W-1:0] REG_RES_LVL = 8'h10;
   localparam logic [ADDR_W-1:0] REG_EV_ON_SEL = 8'h14;
   localparam logic [ADDR_W-1:0] REG_EV_OFF_SEL = 8'h18;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h1C;
   localparam logic [ADDR_W-1:0] REG_CNT_RETRIP = 8'h20;
   localparam logic [ADDR_W-1:0] REG_CNT_FAIL = 8'h24;
   localparam logic [ADDR_W-1:0] REG_CNT_START = 8'h28;
   localparam logic [ADDR_W-1:0] REG_CNT_BLOCK = 8'h2C;
   localparam logic [ADDR_W-1:0] REG_LOG_SEL = 8'h30;
   localparam logic [ADDR_W-1:0] REG_LOG_BASE = 8'h40;
   // ctrl fields
   localparam int CTRL_CRIT_LSB = 0;
   localparam int CTRL_RETRIP_EN = 2;
   localparam int CTRL_CNT_CLR = 3;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
   localparam logic [NUM_EV-1:0] EV_SEL_RESET = 8'hFF;

   // =====================================================
   // carriers
   // =====================================================
   typedef struct packed {
      logic [CUR_W-1:0] phase_max;
      logic [CUR_W-1:0] residual;
      logic primary_trip;
      logic ext_trip;
      logic block;
      logic [GROUP_W-1:0] group;
   } meas_t;

   typedef struct packed {
      logic [TS_W-1:0] stamp;
      logic [2:0] event_id;
      logic [CUR_W-1:0] phase_max;
      logic [CUR_W-1:0] residual;
      logic [DELAY_W-1:0] retrip_left;
      logic [DELAY_W-1:0] fail_left;
      logic [GROUP_W-1:0] group;
   } log_rec_t;

   typedef struct packed {
      logic valid;
      logic on;
      logic [2:0] event_id;
      logic [TS_W-1:0] stamp;
   } event_msg_t;
endpackage

// ### rtl/breaker_fail_delay.sv
// breaker failure delay logic with events, counters and record log
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module breaker_fail_delay (
   input wire logic clk,
   input wire logic rst_b,
   input wire bfail_pkg::meas_t meas,
   input wire logic [bfail_pkg::TS_W-1:0] time_stamp,
   input wire logic [bfail_pkg::ADDR_W-1:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   output logic breaker_fail_output,
   output logic retrip_output,
   output logic start_output,
   output logic blocked_output,
   output bfail_pkg::event_msg_t event_msg
);
   // =====================================================
   // state
   // =====================================================
   typedef struct packed {
      bfail_pkg::bf_state_t st;
      logic [31:0] ctrl;
      logic [bfail_pkg::DELAY_W-1:0] fail_delay;
      logic [bfail_pkg::DELAY_W-1:0] retrip_delay;
      logic [bfail_pkg::CUR_W-1:0] phase_lvl;
      logic [bfail_pkg::CUR_W-1:0] res_lvl;
      logic [bfail_pkg::NUM_EV-1:0] on_sel;
      logic [bfail_pkg::NUM_EV-1:0] off_sel;
      logic [15:0] tick;
      logic [bfail_pkg::DELAY_W-1:0] elapsed;
      logic retrip;
      logic [bfail_pkg::NUM_EV-1:0] ev_level;
      logic [bfail_pkg::NUM_EV-1:0] ev_pend_on;
      logic [bfail_pkg::NUM_EV-1:0] ev_pend_off;
      logic [bfail_pkg::CNT_W-1:0] cnt_retrip;
      logic [bfail_pkg::CNT_W-1:0] cnt_fail;
      logic [bfail_pkg::CNT_W-1:0] cnt_start;
      logic [bfail_pkg::CNT_W-1:0] cnt_block;
      logic [bfail_pkg::LOG_AW-1:0] wr_ptr;
      logic [bfail_pkg::LOG_AW-1:0] log_sel;
      bfail_pkg::event_msg_t msg;
      logic [31:0] rdata;
   } state_t;

   state_t s;
   state_t next_s;
   bfail_pkg::log_rec_t log_mem [bfail_pkg::LOG_DEPTH];
   bfail_pkg::log_rec_t next_rec;
   logic log_we;

   // =====================================================
   // pick-up decode
   // =====================================================
   logic phase_over;
   logic res_over;
   logic cur_over;
   logic pickup;
   logic timing;
   logic tick_hit;
   logic [bfail_pkg::NUM_EV-1:0] ev_now;
   logic [bfail_pkg::NUM_EV-1:0] ev_rise;
   logic [bfail_pkg::NUM_EV-1:0] ev_fall;
   logic [bfail_pkg::NUM_EV-1:0] ev_fire_on;
   logic [bfail_pkg::NUM_EV-1:0] ev_fire_off;
   logic [bfail_pkg::NUM_EV-1:0] ev_clr_on;
   logic [bfail_pkg::NUM_EV-1:0] ev_clr_off;
   logic [2:0] ev_pick;
   logic ev_pick_on;
   logic ev_found;
   bfail_pkg::log_rec_t rd_rec;
   logic [bfail_pkg::DELAY_W-1:0] retrip_left;
   logic [bfail_pkg::DELAY_W-1:0] fail_left;

   assign phase_over = meas.phase_max > s.phase_lvl;
   assign res_over = meas.residual > s.res_lvl;
   assign cur_over = phase_over | res_over;
   assign tick_hit = s.tick == 16'(bfail_pkg::STEP_CYCLES - 1);
   // out-of-range record selections read as zero
   assign rd_rec = (s.log_sel > bfail_pkg::LOG_LAST) ? '0 : log_mem[s.log_sel];
   assign retrip_left = (s.elapsed < s.retrip_delay) ? s.retrip_delay - s.elapsed : '0;
   assign fail_left = (s.elapsed < s.fail_delay) ? s.fail_delay - s.elapsed : '0;

   always_comb begin
      pickup = 1'b0;
      timing = 1'b0;
      case (bfail_pkg::criterion_t'(s.ctrl[bfail_pkg::CTRL_CRIT_LSB +: 2]))
         bfail_pkg::CRIT_CURRENT: begin
            pickup = cur_over;
            timing = cur_over;
         end
         bfail_pkg::CRIT_CUR_AND_OUT: begin
            pickup = cur_over;
            timing = cur_over & meas.primary_trip;
         end
         bfail_pkg::CRIT_CUR_OR_OUT: begin
            pickup = cur_over | meas.primary_trip;
            timing = pickup;
         end
         bfail_pkg::CRIT_INPUT: begin
            pickup = meas.ext_trip;
            timing = meas.ext_trip;
         end
         default: begin
            pickup = 1'b0;
            timing = 1'b0;
         end
      endcase
   end

   // =====================================================
   // event edges, one per event
   // =====================================================
   assign ev_now[bfail_pkg::EV_START] = s.st == bfail_pkg::ST_START
      || s.st == bfail_pkg::ST_FAILED;
   assign ev_now[bfail_pkg::EV_RETRIP] = s.retrip;
   assign ev_now[bfail_pkg::EV_FAIL] = s.st == bfail_pkg::ST_FAILED;
   assign ev_now[bfail_pkg::EV_BLOCK] = s.st == bfail_pkg::ST_BLOCKED;
   assign ev_now[bfail_pkg::EV_OUTMON] = meas.primary_trip;
   assign ev_now[bfail_pkg::EV_SIGNAL] = meas.ext_trip;
   assign ev_now[bfail_pkg::EV_PHASE] = phase_over;
   assign ev_now[bfail_pkg::EV_RES] = res_over;

   genvar gi;
   generate
      for (gi = 0; gi < bfail_pkg::NUM_EV; gi++) begin : g_ev
         assign ev_rise[gi] = ev_now[gi] & ~s.ev_level[gi];
         assign ev_fall[gi] = ~ev_now[gi] & s.ev_level[gi];
         assign ev_fire_on[gi] = ev_rise[gi] & s.on_sel[gi];
         assign ev_fire_off[gi] = ev_fall[gi] & s.off_sel[gi];
      end
   endgenerate

   always_comb begin
      ev_pick = '0;
      ev_pick_on = 1'b0;
      ev_found = 1'b0;
      ev_clr_on = '0;
      ev_clr_off = '0;
      for (int i = bfail_pkg::NUM_EV - 1; i >= 0; i--) begin
         if (s.ev_pend_on[i] || s.ev_pend_off[i]) begin
            ev_pick = 3'(i);
            ev_found = 1'b1;
            // both pending: the edge away from the present level came first
            ev_pick_on = s.ev_pend_on[i] && !(s.ev_pend_off[i] && s.ev_level[i]);
         end
      end
      if (ev_found) begin
         ev_clr_on[ev_pick] = ev_pick_on;
         ev_clr_off[ev_pick] = !ev_pick_on;
      end
   end

   // =====================================================
   // next state
   // =====================================================
   always_comb begin
      next_s = s;
      log_we = 1'b0;
      next_rec = '0;
      next_s.msg.valid = 1'b0;
      // read data stands for one cycle, zero otherwise
      next_s.rdata = '0;
      // program tick divider, free running from reset
      next_s.tick = tick_hit ? '0 : s.tick + 16'h0001;
      if (tick_hit) begin
         case (s.st)
            bfail_pkg::ST_NORMAL: begin
               if (pickup && meas.block) begin
                  next_s.st = bfail_pkg::ST_BLOCKED;
               end else if (pickup) begin
                  next_s.st = bfail_pkg::ST_START;
                  next_s.elapsed = '0;
               end
            end
            bfail_pkg::ST_START: begin
               // block or lost pick-up releases the start
               if (meas.block || !pickup) begin
                  next_s.st = meas.block ? bfail_pkg::ST_BLOCKED : bfail_pkg::ST_NORMAL;
                  next_s.elapsed = '0;
                  next_s.retrip = 1'b0;
               end else if (!timing) begin
                  next_s.elapsed = '0;
                  next_s.retrip = 1'b0;
               end else begin
                  next_s.elapsed = s.elapsed + 20'h00001;
                  if (s.ctrl[bfail_pkg::CTRL_RETRIP_EN]
                      && s.elapsed + 20'h00001 >= s.retrip_delay) begin
                     next_s.retrip = 1'b1;
                  end
                  if (s.elapsed + 20'h00001 >= s.fail_delay) begin
                     next_s.st = bfail_pkg::ST_FAILED;
                  end
               end
            end
            bfail_pkg::ST_FAILED: begin
               // failure drops with the timing condition or on block
               if (!timing || meas.block) begin
                  next_s.st = bfail_pkg::ST_NORMAL;
                  next_s.elapsed = '0;
                  next_s.retrip = 1'b0;
               end
            end
            bfail_pkg::ST_BLOCKED: begin
               // blocked until pick-up or block goes away
               if (!pickup || !meas.block) begin
                  next_s.st = bfail_pkg::ST_NORMAL;
               end
            end
            default: next_s.st = bfail_pkg::ST_NORMAL;
         endcase
      end
      next_s.ev_level = ev_now;
      // set wins over dispatch
      next_s.ev_pend_on = (s.ev_pend_on & ~ev_clr_on) | ev_fire_on;
      next_s.ev_pend_off = (s.ev_pend_off & ~ev_clr_off) | ev_fire_off;
      if (ev_found) begin
         next_s.msg.valid = 1'b1;
         next_s.msg.on = ev_pick_on;
         next_s.msg.event_id = ev_pick;
         next_s.msg.stamp = time_stamp;
      end
      // only ON messages enter the record log
      if (ev_found && ev_pick_on) begin
         log_we = 1'b1;
         next_rec.stamp = time_stamp;
         next_rec.event_id = ev_pick;
         next_rec.phase_max = meas.phase_max;
         next_rec.residual = meas.residual;
         next_rec.retrip_left = retrip_left;
         next_rec.fail_left = fail_left;
         next_rec.group = meas.group;
         next_s.wr_ptr = (s.wr_ptr == bfail_pkg::LOG_LAST) ? '0 : s.wr_ptr + 4'h1;
      end
      if (ev_rise[bfail_pkg::EV_RETRIP]) next_s.cnt_retrip = s.cnt_retrip + 16'h0001;
      if (ev_rise[bfail_pkg::EV_FAIL]) next_s.cnt_fail = s.cnt_fail + 16'h0001;
      if (ev_rise[bfail_pkg::EV_START]) next_s.cnt_start = s.cnt_start + 16'h0001;
      if (ev_rise[bfail_pkg::EV_BLOCK]) next_s.cnt_block = s.cnt_block + 16'h0001;
      if (wr) begin
         case (addr)
            bfail_pkg::REG_CTRL: begin
               // counter clear bit never reads back
               next_s.ctrl = wdata & ~(32'h1 << bfail_pkg::CTRL_CNT_CLR);
               if (wdata[bfail_pkg::CTRL_CNT_CLR]) begin
                  next_s.cnt_retrip = '0;
                  next_s.cnt_fail = '0;
                  next_s.cnt_start = '0;
                  next_s.cnt_block = '0;
               end
            end
            bfail_pkg::REG_FAIL_DELAY: next_s.fail_delay = wdata[bfail_pkg::DELAY_W-1:0];
            bfail_pkg::REG_RETRIP_DELAY: next_s.retrip_delay = wdata[bfail_pkg::DELAY_W-1:0];
            bfail_pkg::REG_PHASE_LVL: next_s.phase_lvl = wdata[bfail_pkg::CUR_W-1:0];
            bfail_pkg::REG_RES_LVL: next_s.res_lvl = wdata[bfail_pkg::CUR_W-1:0];
            bfail_pkg::REG_EV_ON_SEL: next_s.on_sel = wdata[bfail_pkg::NUM_EV-1:0];
            bfail_pkg::REG_EV_OFF_SEL: next_s.off_sel = wdata[bfail_pkg::NUM_EV-1:0];
            bfail_pkg::REG_LOG_SEL: next_s.log_sel = wdata[bfail_pkg::LOG_AW-1:0];
            default: next_s.ctrl = s.ctrl;
         endcase
      end
      if (rd) begin
         case (addr)
            bfail_pkg::REG_CTRL: next_s.rdata = s.ctrl;
            bfail_pkg::REG_FAIL_DELAY: next_s.rdata = 32'(s.fail_delay);
            bfail_pkg::REG_RETRIP_DELAY: next_s.rdata = 32'(s.retrip_delay);
            bfail_pkg::REG_PHASE_LVL: next_s.rdata = 32'(s.phase_lvl);
            bfail_pkg::REG_RES_LVL: next_s.rdata = 32'(s.res_lvl);
            bfail_pkg::REG_EV_ON_SEL: next_s.rdata = 32'(s.on_sel);
            bfail_pkg::REG_EV_OFF_SEL: next_s.rdata = 32'(s.off_sel);
            bfail_pkg::REG_STATUS: next_s.rdata = {5'h00, s.wr_ptr, fail_left, s.retrip, s.st};
            bfail_pkg::REG_CNT_RETRIP: next_s.rdata = 32'(s.cnt_retrip);
            bfail_pkg::REG_CNT_FAIL: next_s.rdata = 32'(s.cnt_fail);
            bfail_pkg::REG_CNT_START: next_s.rdata = 32'(s.cnt_start);
            bfail_pkg::REG_CNT_BLOCK: next_s.rdata = 32'(s.cnt_block);
            bfail_pkg::REG_LOG_SEL: next_s.rdata = 32'(s.log_sel);
            bfail_pkg::REG_LOG_BASE: next_s.rdata = rd_rec.stamp[31:0];
            bfail_pkg::REG_LOG_BASE + 8'h04: next_s.rdata = {16'h0000, rd_rec.stamp[47:32]};
            bfail_pkg::REG_LOG_BASE + 8'h08: next_s.rdata = {rd_rec.phase_max, rd_rec.residual};
            bfail_pkg::REG_LOG_BASE + 8'h0C: next_s.rdata = 32'(rd_rec.retrip_left);
            bfail_pkg::REG_LOG_BASE + 8'h10: next_s.rdata = 32'(rd_rec.fail_left);
            bfail_pkg::REG_LOG_BASE + 8'h14:
               next_s.rdata = {26'h0, rd_rec.group, rd_rec.event_id};
            default: next_s.rdata = '0;
         endcase
      end
   end

   // =====================================================
   // registers
   // =====================================================
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
         s.ctrl <= bfail_pkg::CTRL_RESET;
         s.fail_delay <= bfail_pkg::DEFAULT_FAIL_STEPS;
         s.retrip_delay <= bfail_pkg::DEFAULT_RETRIP_STEPS;
         s.on_sel <= bfail_pkg::EV_SEL_RESET;
         s.off_sel <= bfail_pkg::EV_SEL_RESET;
      end else begin
         s <= next_s;
      end
   end

   always_ff @(posedge clk) begin
      if (log_we) begin
         log_mem[s.wr_ptr] <= next_rec;
      end
   end

   assign rdata = s.rdata;
   assign breaker_fail_output = s.st == bfail_pkg::ST_FAILED;
   assign retrip_output = s.retrip;
   assign start_output = ev_now[bfail_pkg::EV_START];
   assign blocked_output = s.st == bfail_pkg::ST_BLOCKED;
   assign event_msg = s.msg;
endmodule // breaker_fail_delay
`default_nettype wire

// ### test/breaker_fail_monitor.sv
// assertion checker for the breaker failure delay outputs
`timescale 1ns/1ps
`default_nettype none
module breaker_fail_monitor (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [bfail_pkg::ADDR_W-1:0] addr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   input wire logic breaker_fail_output,
   input wire logic retrip_output,
   input wire logic start_output,
   input wire logic blocked_output,
   input wire bfail_pkg::event_msg_t event_msg
);
   // =====================================================
   // program tick replica
   // =====================================================
   logic [15:0] tick_cnt;
   logic tick;
   assign tick = (tick_cnt == 16'(bfail_pkg::STEP_CYCLES - 1));
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tick_cnt <= 16'h0000;
      end else begin
         tick_cnt <= tick ? 16'h0000 : tick_cnt + 16'h0001;
      end
   end
   // =====================================================
   // properties
   // =====================================================
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_fail_needs_start: assert property (breaker_fail_output |-> start_output)
      else $error("failure output without start");
   a_block_holds_off: assert property (blocked_output |-> !start_output && !breaker_fail_output)
      else $error("blocked together with start or failure");
   a_tick_only_change: assert property (!$past(tick) |->
      $stable({start_output, breaker_fail_output, blocked_output, retrip_output}))
      else $error("state output moved off the program tick");
   a_fail_after_start: assert property ($rose(breaker_fail_output) |-> $past(start_output))
      else $error("failure without a prior start");
   a_start_event: assert property ($rose(start_output) |-> ##[1:8]
      (event_msg.valid && event_msg.on && event_msg.event_id == 3'h0))
      else $error("start on event missing");
   a_fail_event: assert property ($rose(breaker_fail_output) |-> ##[1:8]
      (event_msg.valid && event_msg.on && event_msg.event_id == 3'h2))
      else $error("failure on event missing");
   a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
      else $error("read data outside read answer cycle");
   a_unmapped_zero: assert property (rd && addr == 8'hFC |=> rdata == 32'h0000_0000)
      else $error("unmapped read not zero");
endmodule // breaker_fail_monitor
bind breaker_fail_delay breaker_fail_monitor u_mon (
   .clk(clk),
   .rst_b(rst_b),
   .addr(addr),
   .rd(rd),
   .rdata(rdata),
   .breaker_fail_output(breaker_fail_output),
   .retrip_output(retrip_output),
   .start_output(start_output),
   .blocked_output(blocked_output),
   .event_msg(event_msg)
);
`default_nettype wire

// ### test/breaker_failure_delay_logic_tb_top.sv
// self-checking bench for the breaker failure delay logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_mismatch++; $display("CHECK FAILED %0t ns value mismatch", $time); end end
module breaker_failure_delay_logic_tb_top;
   logic clk;
   logic rst_b;
   bfail_pkg::meas_t meas;
   bfail_pkg::event_msg_t event_msg;
   logic [bfail_pkg::TS_W-1:0] time_stamp = '0;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic wr;
   logic rd;
   logic rd_q = 1'b0;
   logic [31:0] rdata;
   logic breaker_fail_output;
   logic retrip_output;
   logic start_output;
   logic blocked_output;
   logic fault_on;
   logic trip_noise = 1'b0;
   logic [15:0] res_noise = 16'h0000;
   logic [31:0] rng = 32'h3;
   logic start_seen = 1'b0;
   logic [31:0] exp_q[$];
   int n_mismatch = 0;
   int samples_checked = 0;
   int i;
   // =====================================================
   // structure
   // =====================================================
   breaker_fail_delay DUT (.clk(clk), .rst_b(rst_b), .meas(meas), .time_stamp(time_stamp),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .breaker_fail_output(breaker_fail_output), .retrip_output(retrip_output),
      .start_output(start_output), .blocked_output(blocked_output), .event_msg(event_msg));
   feeder_breaker_model u_feeder (.clk(clk), .rst_b(rst_b), .fault_on(fault_on),
      .trip_noise(trip_noise), .res_noise(res_noise), .group(3'h1),
      .breaker_fail_output(breaker_fail_output), .meas(meas));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // =====================================================
   // bus tasks and closing
   // =====================================================
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic test_done;
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // =====================================================
   // watcher: read answers and events
   // =====================================================
   always @(posedge clk) begin
      if (rd_q === 1'b1 && exp_q.size() > 0) begin
         `CHK(rdata, exp_q.pop_front())
      end
      if (event_msg.valid === 1'b1) begin
         `CHK(time_stamp - event_msg.stamp < 48'h10, 1'b1)
         if (event_msg.on === 1'b1 && event_msg.event_id === 3'h0) begin
            start_seen <= 1'b1;
         end
      end
      rd_q <= rd;
      time_stamp <= time_stamp + 48'h1;
      if (fault_on) begin
         rng <= xorshift(rng);
         trip_noise <= rng[0];
         res_noise <= rng[31:16];
      end
   end
   // =====================================================
   // main sequence
   // =====================================================
   initial begin
      rst_b = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      fault_on = 1'b0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      reg_rd(bfail_pkg::REG_CTRL, 32'h0000_0004);
      reg_rd(bfail_pkg::REG_FAIL_DELAY, 32'h0000_0028);
      reg_rd(bfail_pkg::REG_RETRIP_DELAY, 32'h0000_0014);
      reg_rd(bfail_pkg::REG_EV_ON_SEL, 32'h0000_00FF);
      reg_rd(8'hFC, 32'h0000_0000);
      reg_wr(bfail_pkg::REG_CTRL, 32'h0000_0004);
      reg_wr(bfail_pkg::REG_FAIL_DELAY, 32'h0000_0001);
      reg_wr(bfail_pkg::REG_RETRIP_DELAY, 32'h0000_0001);
      reg_wr(bfail_pkg::REG_PHASE_LVL, 32'h0000_0100);
      reg_wr(bfail_pkg::REG_RES_LVL, 32'h0000_FFFF);
      reg_rd(bfail_pkg::REG_FAIL_DELAY, 32'h0000_0001);
      // random primary trip must not matter in current-only mode
      fault_on <= 1'b1;
      for (i = 0; i < 60000 && start_output !== 1'b1; i++) @(posedge clk);
      `CHK(start_output, 1'b1)
      `CHK(breaker_fail_output, 1'b0)
      if (start_output !== 1'b1) test_done();
      repeat (20) @(posedge clk);
      `CHK(start_seen, 1'b1)
      for (i = 0; i < 60000 && breaker_fail_output !== 1'b1; i++) @(posedge clk);
      `CHK(breaker_fail_output, 1'b1)
      `CHK(retrip_output, 1'b1)
      `CHK(blocked_output, 1'b0)
      if (breaker_fail_output !== 1'b1) test_done();
      reg_rd(bfail_pkg::REG_CNT_FAIL, 32'h0000_0001);
      reg_rd(bfail_pkg::REG_CNT_START, 32'h0000_0001);
      reg_wr(bfail_pkg::REG_CTRL, 32'h0000_000C);
      reg_rd(bfail_pkg::REG_CTRL, 32'h0000_0004);
      reg_rd(bfail_pkg::REG_CNT_FAIL, 32'h0000_0000);
      repeat (4) @(posedge clk);
      test_done();
   end
endmodule // breaker_failure_delay_logic_tb_top
`default_nettype wire

// ### test/feeder_breaker_model.sv
// feeder model: fault current source, trip contact and upstream breaker
`timescale 1ns/1ps
`default_nettype none
module feeder_breaker_model #(
   parameter int OPEN_CYCLES = 20
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic fault_on,
   input wire logic trip_noise,
   input wire logic [bfail_pkg::CUR_W-1:0] res_noise,
   input wire logic [bfail_pkg::GROUP_W-1:0] group,
   input wire logic breaker_fail_output,
   output var bfail_pkg::meas_t meas
);
   logic [7:0] open_cnt;
   logic upstream_open;
   // upstream breaker needs some cycles to open after the command
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         open_cnt <= 8'h00;
         upstream_open <= 1'b0;
      end else if (breaker_fail_output && !upstream_open) begin
         open_cnt <= open_cnt + 8'h01;
         upstream_open <= (open_cnt == 8'(OPEN_CYCLES));
      end
   end
   always_comb begin
      meas.phase_max = (fault_on && !upstream_open) ? 16'h0200 : 16'h0010;
      meas.residual = res_noise;
      meas.primary_trip = trip_noise;
      meas.ext_trip = 1'b0;
      meas.block = 1'b0;
      meas.group = group;
   end
endmodule // feeder_breaker_model
`default_nettype wire
